// *** ddr2_command_pin_interface.sv ***
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
// What this block does
// - capture pins on rising clock crossing only
// - read beats leave on both clock edges
// - clock gate runs clocks, buffers, drivers
// - gate low picks power-down or self refresh
// - gate synchronous except self-refresh exit
// - input buffers off in power-down and self refresh, clock buffer off in self refresh only
// - chip select high masks command, part code
// - termination on for data, strobes, masks
// - termination pin ignored when disabled
// - four strobes together encode command
// - masked write bytes are not stored
// - bank select chooses target bank
// - bank select picks base or extended mode
// - row on activate, column and auto-precharge
// - precharge one bank or all banks
// - mode loads take opcode from address
module ddr2_command_pin_interface
   import ddr2_pin_pkg::*;
#(
   parameter int BANKS   = 4,
   parameter int BANK_W  = 2,
   parameter int ADDR_W  = 13,
   parameter int DATA_W  = 16,
   parameter int COL_IDX = 4
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   arst_n_i,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // controller pins
   input  wire logic                   clock_gate_in_i,
   input  wire logic                   chip_select_n_i,
   input  wire logic                   row_strobe_n_i,
   input  wire logic                   column_strobe_n_i,
   input  wire logic                   write_strobe_n_i,
   input  wire logic [BANK_W-1:0]      bank_select_i,
   input  wire logic [ADDR_W-1:0]      addr_i,
   input  wire logic                   termination_on_i,
   // write beats, rise and fall strobe halves
   input  wire logic [DATA_W-1:0]      wr_rise_data_i,
   input  wire logic [DATA_W-1:0]      wr_fall_data_i,
   input  wire logic [1:0]             wr_rise_mask_i,
   input  wire logic [1:0]             wr_fall_mask_i,
   // read beats for the double-edge output cell
   output logic [DATA_W-1:0]           rd_rise_data_o,
   output logic [DATA_W-1:0]           rd_fall_data_o,
   output logic                        rd_valid_o,
   // buffer, driver and termination controls
   output logic                        clk_run_o,
   output logic                        clkbuf_en_o,
   output logic                        inbuf_en_o,
   output logic                        drv_en_o,
   output logic                        term_en_o,
   output logic [1:0]                  pwr_state_o
);

   localparam int IDX_W = BANK_W + COL_IDX;
   localparam int WORDS = 1 << IDX_W;

   // ****************************************
   // state declarations
   // ****************************************
   cmd_bus_if #(.BANK_W(BANK_W), .ADDR_W(ADDR_W)) bus ();

   pwr_t                    pwr, next_pwr;
   logic [1:0]              ctrl, next_ctrl;
   logic [`MODE_W-1:0]      mode_reg [4];
   logic [`MODE_W-1:0]      next_mode [4];
   cmd_t                    last_cmd, next_last_cmd;
   logic [BANKS-1:0]        open_mask;
   logic [BANKS*ADDR_W-1:0] open_rows;
   logic [DATA_W-1:0]       mem [WORDS];
   logic [2:0]              wr_left, next_wr_left;
   logic [2:0]              rd_left, next_rd_left;
   logic [IDX_W-1:0]        wr_idx, next_wr_idx;
   logic [IDX_W-1:0]        rd_idx, next_rd_idx;
   logic [IDX_W-1:0]        wr_idx1, rd_idx1;
   logic [2:0]              burst_pairs;
   logic                    accept;
   logic                    rtt_on;
   logic                    next_pready, next_pslverr;
   logic [31:0]             next_prdata;
   logic                    apb_wr;
   logic                    next_clk_run, next_clkbuf, next_inbuf, next_drv, next_term;

   // ****************************************
   // pin capture and bank tracking
   // ****************************************
   // commands only pass while running and enabled
   assign accept = (pwr == pwr_run) && ctrl[`CTRL_ENABLE_BIT];

   cmd_decoder #(.BANK_W(BANK_W), .ADDR_W(ADDR_W)) u_dec (
      .core_clk_i        (core_clk_i),
      .arst_n_i          (arst_n_i),
      .accept_i          (accept),
      .clock_gate_in_i   (clock_gate_in_i),
      .chip_select_n_i   (chip_select_n_i),
      .row_strobe_n_i    (row_strobe_n_i),
      .column_strobe_n_i (column_strobe_n_i),
      .write_strobe_n_i  (write_strobe_n_i),
      .bank_select_i     (bank_select_i),
      .addr_i            (addr_i),
      .termination_on_i  (termination_on_i),
      .bus               (bus)
   );

   bank_tracker #(.BANKS(BANKS), .BANK_W(BANK_W), .ADDR_W(ADDR_W)) u_trk (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .bus        (bus),
      .open_o     (open_mask),
      .row_o      (open_rows)
   );

   // ****************************************
   // power state machine
   // ****************************************
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         pwr_run: begin
            if (!bus.gate_q) begin
               if (bus.cmd == cmd_refresh) begin
                  next_pwr = pwr_self_ref;
               end else if (|open_mask) begin
                  next_pwr = pwr_act_pd;
               end else begin
                  next_pwr = pwr_pre_pd;
               end
            end
         end
         pwr_pre_pd, pwr_act_pd: begin
            if (bus.gate_q) begin
               next_pwr = pwr_run;
            end
         end
         pwr_self_ref: begin
            if (clock_gate_in_i) begin
               next_pwr = pwr_run;
            end
         end
         default: next_pwr = pwr_run;
      endcase
   end

   // buffer and driver enables follow the gate and power state
   always_comb begin
      rtt_on       = mode_reg[1][`EMR1_RTT_LO_BIT] | mode_reg[1][`EMR1_RTT_HI_BIT];
      next_clk_run = (next_pwr == pwr_run);
      next_drv     = (next_pwr == pwr_run);
      next_inbuf   = (next_pwr == pwr_run);
      next_clkbuf  = (next_pwr != pwr_self_ref);
      // termination covers data, both strobe pairs and both byte masks
      next_term    = bus.term_q && rtt_on && !ctrl[`CTRL_TERM_OFF_BIT] &&
                     (pwr == pwr_run);
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pwr         <= pwr_run;
         clk_run_o   <= 1'b0;
         drv_en_o    <= 1'b0;
         inbuf_en_o  <= 1'b0;
         clkbuf_en_o <= 1'b0;
         term_en_o   <= 1'b0;
         pwr_state_o <= 2'h0;
      end else begin
         pwr         <= next_pwr;
         clk_run_o   <= next_clk_run;
         drv_en_o    <= next_drv;
         inbuf_en_o  <= next_inbuf;
         clkbuf_en_o <= next_clkbuf;
         term_en_o   <= next_term;
         pwr_state_o <= next_pwr;
      end
   end

   // ****************************************
   // mode registers and control register
   // ****************************************
   assign apb_wr = psel && penable && pready && pwrite;

   always_comb begin
      next_ctrl     = ctrl;
      next_last_cmd = last_cmd;
      for (int i = 0; i < 4; i++) begin
         next_mode[i] = mode_reg[i];
      end
      if (bus.cmd != cmd_nop && bus.cmd != cmd_deselect) begin
         next_last_cmd = bus.cmd;
      end
      if (bus.cmd == cmd_mode_load || bus.cmd == cmd_ext_mode_load) begin
         next_mode[bus.bank] = bus.addr;
      end
      if (apb_wr && paddr == `REG_CTRL_OFF) begin
         next_ctrl = pwdata[1:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl     <= `CTRL_RESET;
         last_cmd <= cmd_nop;
         for (int i = 0; i < 4; i++) begin
            mode_reg[i] <= `MODE_RESET;
         end
      end else begin
         ctrl     <= next_ctrl;
         last_cmd <= next_last_cmd;
         for (int i = 0; i < 4; i++) begin
            mode_reg[i] <= next_mode[i];
         end
      end
   end

   // ****************************************
   // burst engine and storage
   // ****************************************
   assign burst_pairs = (mode_reg[0][`MODE_BL_LSB +: 3] == `MODE_BL8_CODE) ?
                        `PAIRS_BL8 : `PAIRS_BL4;
   assign wr_idx1     = wr_idx + 1'b1;
   assign rd_idx1     = rd_idx + 1'b1;

   always_comb begin
      next_wr_left = (wr_left != 3'h0) ? wr_left - 3'h1 : 3'h0;
      next_rd_left = (rd_left != 3'h0) ? rd_left - 3'h1 : 3'h0;
      next_wr_idx  = (wr_left != 3'h0) ? IDX_W'(wr_idx + 2'h2) : wr_idx;
      next_rd_idx  = (rd_left != 3'h0) ? IDX_W'(rd_idx + 2'h2) : rd_idx;
      if (bus.cmd == cmd_write) begin
         next_wr_left = burst_pairs;
         next_wr_idx  = {bus.bank, bus.addr[COL_IDX-1:0]};
      end
      if (bus.cmd == cmd_read) begin
         next_rd_left = burst_pairs;
         next_rd_idx  = {bus.bank, bus.addr[COL_IDX-1:0]};
      end
   end

   // masked bytes keep their old contents
   always_ff @(posedge core_clk_i) begin
      if (wr_left != 3'h0) begin
         if (!wr_rise_mask_i[0]) mem[wr_idx][7:0]   <= wr_rise_data_i[7:0];
         if (!wr_rise_mask_i[1]) mem[wr_idx][15:8]  <= wr_rise_data_i[15:8];
         if (!wr_fall_mask_i[0]) mem[wr_idx1][7:0]  <= wr_fall_data_i[7:0];
         if (!wr_fall_mask_i[1]) mem[wr_idx1][15:8] <= wr_fall_data_i[15:8];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_left        <= 3'h0;
         rd_left        <= 3'h0;
         wr_idx         <= '0;
         rd_idx         <= '0;
         rd_valid_o     <= 1'b0;
         rd_rise_data_o <= '0;
         rd_fall_data_o <= '0;
      end else begin
         wr_left        <= next_wr_left;
         rd_left        <= next_rd_left;
         wr_idx         <= next_wr_idx;
         rd_idx         <= next_rd_idx;
         rd_valid_o     <= (rd_left != 3'h0);
         rd_rise_data_o <= mem[rd_idx];
         rd_fall_data_o <= mem[rd_idx1];
      end
   end

   // ****************************************
   // apb slave, one wait-free access phase
   // ****************************************
   always_comb begin
      next_pready  = psel && !penable;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (paddr == `REG_CTRL_OFF) begin
         next_prdata[1:0] = ctrl;
      end else if (paddr == `REG_STATUS_OFF) begin
         next_prdata[`STAT_PWR_LSB +: 2]    = pwr;
         next_prdata[`STAT_OPEN_LSB +: 4]   = open_mask;
         next_prdata[`STAT_CMD_LSB +: 4]    = last_cmd;
      end else if (paddr == `REG_MODE0_OFF) begin
         next_prdata[`MODE_W-1:0] = mode_reg[0];
      end else if (paddr == `REG_MODE1_OFF) begin
         next_prdata[`MODE_W-1:0] = mode_reg[1];
      end else if (paddr == `REG_MODE2_OFF) begin
         next_prdata[`MODE_W-1:0] = mode_reg[2];
      end else if (paddr == `REG_MODE3_OFF) begin
         next_prdata[`MODE_W-1:0] = mode_reg[3];
      end else begin
         next_pslverr = 1'b1;
      end
      if (!(psel && !penable) || pwrite) begin
         next_prdata = 32'h0000_0000;
      end
      if (!(psel && !penable)) begin
         next_pslverr = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

endmodule

// *** ddr2_pin_map.svh ***
`ifndef DDR2_PIN_MAP_SVH
`define DDR2_PIN_MAP_SVH

// ****************************************
// apb register offsets
// ****************************************
`define APB_ADDR_W        12
`define REG_CTRL_OFF      12'h000
`define REG_STATUS_OFF    12'h004
`define REG_MODE0_OFF     12'h008
`define REG_MODE1_OFF     12'h00c
`define REG_MODE2_OFF     12'h010
`define REG_MODE3_OFF     12'h014

// ****************************************
// control register fields and reset value
// ****************************************
`define CTRL_ENABLE_BIT   0
`define CTRL_TERM_OFF_BIT 1
`define CTRL_RESET        2'h1

// ****************************************
// status register fields
// ****************************************
`define STAT_PWR_LSB      0
`define STAT_OPEN_LSB     4
`define STAT_CMD_LSB      8

// ****************************************
// mode register fields and reset values
// ****************************************
`define MODE_W            13
`define MODE_RESET        13'h0000
`define MODE_BL_LSB       0
`define MODE_BL8_CODE     3'h3
`define EMR1_RTT_LO_BIT   2
`define EMR1_RTT_HI_BIT   6
`define PRE_ALL_BIT       10
`define AUTO_PRE_BIT      10

// ****************************************
// burst timing counts in clock cycles
// ****************************************
`define PAIRS_BL4         3'h2
`define PAIRS_BL8         3'h4

`endif

// *** ddr2_pin_pkg.sv ***
package ddr2_pin_pkg;

   // decoded command of one clock edge
   typedef enum logic [3:0] {
      cmd_deselect,
      cmd_nop,
      cmd_mode_load,
      cmd_ext_mode_load,
      cmd_refresh,
      cmd_precharge,
      cmd_activate,
      cmd_write,
      cmd_read,
      cmd_reserved
   } cmd_t;

   // power state of the device
   typedef enum logic [1:0] {
      pwr_run,
      pwr_pre_pd,
      pwr_act_pd,
      pwr_self_ref
   } pwr_t;

endpackage

// *** cmd_bus_if.sv ***
`timescale 1ns/1ps
interface cmd_bus_if
   import ddr2_pin_pkg::*;
#(
   parameter int BANK_W = 2,
   parameter int ADDR_W = 13
);
   cmd_t              cmd;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic              term_q;
   logic              gate_q;

   modport dec (output cmd, bank, addr, term_q, gate_q);
   modport trk (input  cmd, bank, addr, term_q, gate_q);
endinterface

// *** cmd_decoder.sv ***
`timescale 1ns/1ps
module cmd_decoder
   import ddr2_pin_pkg::*;
#(
   parameter int BANK_W = 2,
   parameter int ADDR_W = 13
) (
   input  wire logic              core_clk_i,
   input  wire logic              arst_n_i,
   input  wire logic              accept_i,
   input  wire logic              clock_gate_in_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              row_strobe_n_i,
   input  wire logic              column_strobe_n_i,
   input  wire logic              write_strobe_n_i,
   input  wire logic [BANK_W-1:0] bank_select_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic              termination_on_i,
   cmd_bus_if.dec                 bus
);

   cmd_t              next_cmd;
   logic [BANK_W-1:0] next_bank;
   logic [ADDR_W-1:0] next_addr;
   logic              next_term;

   // decode the strobes of this edge
   always_comb begin
      next_cmd  = cmd_nop;
      next_bank = bus.bank;
      next_addr = bus.addr;
      next_term = bus.term_q;
      if (accept_i) begin
         next_bank = bank_select_i;
         next_addr = addr_i;
         next_term = termination_on_i;
         if (chip_select_n_i) begin
            next_cmd = cmd_deselect;
         end else begin
            case ({row_strobe_n_i, column_strobe_n_i, write_strobe_n_i})
               3'h0: next_cmd = (bank_select_i == '0) ? cmd_mode_load
                                                     : cmd_ext_mode_load;
               3'h1: next_cmd = cmd_refresh;
               3'h2: next_cmd = cmd_precharge;
               3'h3: next_cmd = cmd_activate;
               3'h4: next_cmd = cmd_write;
               3'h5: next_cmd = cmd_read;
               3'h6: next_cmd = cmd_reserved;
               default: next_cmd = cmd_nop;
            endcase
         end
      end
   end

   // capture on the rising crossing only
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus.cmd    <= cmd_nop;
         bus.bank   <= '0;
         bus.addr   <= '0;
         bus.term_q <= 1'b0;
         bus.gate_q <= 1'b0;
      end else begin
         bus.cmd    <= next_cmd;
         bus.bank   <= next_bank;
         bus.addr   <= next_addr;
         bus.term_q <= next_term;
         bus.gate_q <= clock_gate_in_i;
      end
   end

endmodule

// *** bank_tracker.sv ***
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
module bank_tracker
   import ddr2_pin_pkg::*;
#(
   parameter int BANKS  = 4,
   parameter int BANK_W = 2,
   parameter int ADDR_W = 13
) (
   input  wire logic               core_clk_i,
   input  wire logic               arst_n_i,
   cmd_bus_if.trk                  bus,
   output logic [BANKS-1:0]        open_o,
   output logic [BANKS*ADDR_W-1:0] row_o
);

   genvar b;
   generate
      for (b = 0; b < BANKS; b++) begin : g_bank
         logic              next_open;
         logic [ADDR_W-1:0] next_row;
         logic              hit;

         // per bank open flag and row
         always_comb begin
            hit       = (bus.bank == BANK_W'(b));
            next_open = open_o[b];
            next_row  = row_o[b*ADDR_W +: ADDR_W];
            if (bus.cmd == cmd_activate && hit) begin
               next_open = 1'b1;
               next_row  = bus.addr;
            end else if (bus.cmd == cmd_precharge &&
                         (hit || bus.addr[`PRE_ALL_BIT])) begin
               next_open = 1'b0;
            end else if ((bus.cmd == cmd_read || bus.cmd == cmd_write) && hit &&
                         bus.addr[`AUTO_PRE_BIT]) begin
               next_open = 1'b0;
            end
         end

         always_ff @(posedge core_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               open_o[b]                  <= 1'b0;
               row_o[b*ADDR_W +: ADDR_W]  <= '0;
            end else begin
               open_o[b]                  <= next_open;
               row_o[b*ADDR_W +: ADDR_W]  <= next_row;
            end
         end
      end
   endgenerate

endmodule

// *** ddr2_pin_chk_sva.sv ***
`timescale 1ns/1ps
module pin_checker (
   input wire logic       core_clk_i,
   input wire logic       arst_n_i,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       clock_gate_in_i,
   input wire logic       chip_select_n_i,
   input wire logic       row_strobe_n_i,
   input wire logic       column_strobe_n_i,
   input wire logic       write_strobe_n_i,
   input wire logic       termination_on_i,
   input wire logic       rd_valid_o,
   input wire logic       clk_run_o,
   input wire logic       clkbuf_en_o,
   input wire logic       inbuf_en_o,
   input wire logic       drv_en_o,
   input wire logic       term_en_o,
   input wire logic [1:0] pwr_state_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ****************************************
   // apb answer timing
   // ****************************************
   a_pready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_pready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // ****************************************
   // power states and enables
   // ****************************************
   a_gate_low_entry: assert property (pwr_state_o == 2'h0 && !clock_gate_in_i
      |-> ##2 pwr_state_o != 2'h0) else $error("no power-down entry");
   a_pd_exit_sync: assert property (pwr_state_o inside {2'h1, 2'h2} && clock_gate_in_i
      |-> ##2 pwr_state_o == 2'h0) else $error("no power-down exit");
   a_sr_exit_fast: assert property (pwr_state_o == 2'h3 && clock_gate_in_i
      |=> pwr_state_o == 2'h0) else $error("no self refresh exit");
   a_pd_buffers_off: assert property (pwr_state_o inside {2'h1, 2'h2}
      |-> !clk_run_o && !inbuf_en_o && !drv_en_o && clkbuf_en_o)
      else $error("power-down enables");
   a_sr_buffers_off: assert property (pwr_state_o == 2'h3 |-> !clkbuf_en_o
      && !inbuf_en_o && !drv_en_o) else $error("self refresh enables");
   a_run_resumes: assert property (pwr_state_o != 2'h0 ##1 pwr_state_o == 2'h0
      |-> clk_run_o && inbuf_en_o && drv_en_o && clkbuf_en_o) else $error("run enables");
   // ****************************************
   // command decode, read beats, termination
   // ****************************************
   a_read_cause: assert property ($rose(rd_valid_o) |-> $past(!chip_select_n_i
      && row_strobe_n_i && !column_strobe_n_i && write_strobe_n_i, 3))
      else $error("read beats without read command");
   a_read_two_pairs: assert property ($rose(rd_valid_o) |=> rd_valid_o ##1 !rd_valid_o)
      else $error("read pair count");
   a_term_from_pin: assert property (term_en_o |-> $past(termination_on_i, 2))
      else $error("termination without pin");
   cover property (pwr_state_o == 2'h3);
   cover property (pwr_state_o == 2'h2);
   cover property ($rose(rd_valid_o));
   cover property (pslverr);
endmodule

bind ddr2_command_pin_interface pin_checker chk (.*);

// *** ddr2_ctrl_model.sv ***
`timescale 1ns/1ps
module ddr2_ctrl_model (
   input  wire logic        core_clk_i,
   output logic             gate_o,
   output logic             cs_n_o,
   output logic             ras_n_o,
   output logic             cas_n_o,
   output logic             we_n_o,
   output logic [1:0]       bank_o,
   output logic [12:0]      addr_o,
   output logic             term_o
);
   // ****************************************
   // pins idle deselected, gate high
   // ****************************************
   initial begin
      gate_o = 1'b1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
      bank_o = 2'h0;
      addr_o = 13'h0000;
      term_o = 1'b0;
   end
   // gate and termination levels, gate only moved between bursts
   task level(input logic g, input logic t);
      gate_o <= g;
      term_o <= t;
   endtask
   // one command edge then a nop edge, released lines inverted
   task send(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= code;
      bank_o <= b;
      addr_o <= a;
      @(posedge core_clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
      bank_o <= ~b;
      addr_o <= ~a;
      @(posedge core_clk_i);
   endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "ddr2_pin_map.svh"
module tb;
   logic core_clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [15:0] wr_rise_data_i = 16'h0, wr_fall_data_i = 16'h0, rd_rise_data_o, rd_fall_data_o;
   logic [1:0]  wr_rise_mask_i = 2'h3, wr_fall_mask_i = 2'h3, bank_select_i, pwr_state_o;
   logic [12:0] addr_i;
   logic pready, pslverr, err, clock_gate_in_i, chip_select_n_i, row_strobe_n_i;
   logic column_strobe_n_i, write_strobe_n_i, termination_on_i, rd_valid_o;
   logic clk_run_o, clkbuf_en_o, inbuf_en_o, drv_en_o, term_en_o;
   int   fails = 0, checks = 0;
   always #20 core_clk_i = ~core_clk_i;
   ddr2_command_pin_interface uut (.*);
   ddr2_ctrl_model pm (.core_clk_i, .gate_o(clock_gate_in_i), .cs_n_o(chip_select_n_i),
      .ras_n_o(row_strobe_n_i), .cas_n_o(column_strobe_n_i), .we_n_o(write_strobe_n_i),
      .bank_o(bank_select_i), .addr_o(addr_i), .term_o(termination_on_i));
   // ****************************************
   // report, compare and bus tasks
   // ****************************************
   task stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // apb access, entered just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk_i);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         fails++;
         stop_test();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", e, r);
   endtask
   task st(input logic [3:0] e);
      apb(1'b0, `REG_STATUS_OFF, 32'h0);
      chk("open banks", {28'h0, e}, {28'h0, r[7:4]});
   endtask
   // s picks termination, power state, clock buffer or clock run
   task pin(input string n, input int c, input logic [31:0] e, input int s);
      repeat (c) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(n, e, s == 0 ? term_en_o : s == 1 ? pwr_state_o : s == 2 ? clkbuf_en_o : clk_run_o);
      @(posedge core_clk_i);
   endtask
   // write burst of two pairs, mask on the third beat
   task wb(input logic [12:0] a, input logic [63:0] d, input logic [1:0] m);
      pm.send(4'h4, 2'h2, a);
      {wr_rise_data_i, wr_fall_data_i} <= d[63:32]; {wr_rise_mask_i, wr_fall_mask_i} <= 4'h0;
      @(posedge core_clk_i);
      {wr_rise_data_i, wr_fall_data_i} <= d[31:0]; wr_rise_mask_i <= m;
      @(posedge core_clk_i);
      {wr_rise_data_i, wr_fall_data_i} <= ~d[31:0]; {wr_rise_mask_i, wr_fall_mask_i} <= 4'hf;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd(`REG_CTRL_OFF, 32'h1);
      rd(`REG_MODE0_OFF, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, r);
      apb(1'b1, `REG_MODE0_OFF, 32'h5);
      rd(`REG_MODE0_OFF, 32'h0);
      apb(1'b1, `REG_CTRL_OFF, 32'h3);
      rd(`REG_CTRL_OFF, 32'h3);
      apb(1'b1, `REG_CTRL_OFF, 32'h1);
      $display("test registers done");
      pm.send(4'h0, 2'h0, 13'h0a52);
      pm.send(4'h0, 2'h2, 13'h1abc);
      rd(`REG_MODE0_OFF, 32'h0a52);
      rd(`REG_MODE2_OFF, 32'h1abc);
      rd(`REG_MODE1_OFF, 32'h0);
      $display("test mode loads done");
      pm.send(4'h3, 2'h1, 13'h1fff);
      pm.send(4'h3, 2'h3, 13'h0001);
      pm.send(4'hb, 2'h0, 13'h0000);
      st(4'ha);
      pm.send(4'h2, 2'h1, 13'h0000);
      st(4'h8);
      pm.send(4'h3, 2'h1, 13'h0002);
      pm.send(4'h2, 2'h0, 13'h0400);
      st(4'h0);
      $display("test banks done");
      pm.send(4'h3, 2'h2, 13'h0010);
      wb(13'h0004, 64'ha1a1b2b2c3c3d4d4, 2'h0);
      wb(13'h0004, 64'h12345678ffff9abc, 2'h1);
      pm.send(4'h5, 2'h2, 13'h0404);
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("read pair0", 32'h12345678, {rd_rise_data_o, rd_fall_data_o});
      @(negedge core_clk_i);
      chk("read pair1", 32'hffc39abc, {rd_rise_data_o, rd_fall_data_o});
      @(posedge core_clk_i);
      st(4'h0);
      $display("test data done");
      pm.level(1'b1, 1'b1);
      pin("term off", 2, 32'h0, 0);
      pm.send(4'h0, 2'h1, 13'h0004);
      pin("term on", 1, 32'h1, 0);
      apb(1'b1, `REG_CTRL_OFF, 32'h3);
      pin("term forced", 0, 32'h0, 0);
      apb(1'b1, `REG_CTRL_OFF, 32'h1);
      pm.level(1'b1, 1'b0);
      $display("test termination done");
      pm.send(4'h3, 2'h0, 13'h0001);
      pm.level(1'b0, 1'b0);
      pin("active pd", 2, 32'h2, 1);
      pm.level(1'b1, 1'b0);
      pin("pd exit", 2, 32'h0, 1);
      pm.send(4'h2, 2'h0, 13'h0400);
      pm.level(1'b0, 1'b0);
      pin("precharge pd", 2, 32'h1, 1);
      pm.level(1'b1, 1'b0);
      pin("pd exit", 2, 32'h0, 1);
      pm.level(1'b0, 1'b0);
      pm.send(4'h1, 2'h0, 13'h0000);
      pin("self refresh", 0, 32'h3, 1);
      pin("clock buffer", 0, 32'h0, 2);
      pm.level(1'b1, 1'b0);
      pin("sr exit", 1, 32'h0, 1);
      pin("run clock", 0, 32'h1, 3);
      $display("test power done");
      stop_test();
   end
endmodule
